// >>> rtl/pfdd_pkg.sv
package pfdd_pkg;

  // Register word indices; byte address is index times four
  localparam logic [5:0] IDX_EVT_CTRL = 6'h09;
  localparam logic [5:0] IDX_FLAGS = 6'h0D;
  localparam logic [5:0] IDX_RESUME = 6'h0F;
  localparam logic [5:0] IDX_INPUT_B = 6'h11;
  localparam logic [5:0] IDX_FAULT_DEF = 6'h12;
  localparam logic [5:0] IDX_DLY_SETUP = 6'h14;
  localparam logic [5:0] IDX_DLY_LEN = 6'h15;
  localparam logic [5:0] IDX_FRAC_SEL = 6'h18;
  localparam logic [5:0] IDX_FRAC_STEP = 6'h19;
  localparam logic [5:0] IDX_HALT = 6'h1E;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MODE_MASK = 8'h0F;
  localparam logic [7:0] DLY_SETUP_MASK = 8'h3F;
  localparam logic [7:0] FRAC_SEL_MASK = 8'h03;
  localparam logic [7:0] FRAC_STEP_MASK = 8'h0F;
  localparam logic [7:0] HALT_MASK = 8'h05;
  localparam int TRIG_EN_BIT = 0;
  localparam int FLAG_TRIG_B_BIT = 3;
  localparam int RESUME_BIT = 0;
  localparam int PIN_EN_LSB = 4;
  localparam int NUM_PINS = 4;
  localparam int PIN_B_IDX = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_NONE = 4'h0,
    MODE_JUMP_OPPOSITE_AND_HOLD = 4'h1,
    MODE_RUN_OPPOSITE_AND_HOLD = 4'h2,
    MODE_RUN_OPPOSITE_WHILE_FAULTED = 4'h3,
    MODE_STOP_ALL_KEEP_PERIOD = 4'h4,
    MODE_DEADTIME_WHILE_FAULTED = 4'h5,
    MODE_STOP_ALL_JUMP_NEXT = 4'h6,
    MODE_STOP_ALL_UNTIL_SOFTWARE = 4'h7,
    MODE_EDGE_STOP_NEXT_CYCLE = 4'h8,
    MODE_EDGE_STOP_KEEP_PERIOD = 4'h9,
    MODE_LEVEL_STOP_KEEP_PERIOD = 4'hA
  } pfdd_mode_t;

  typedef enum logic [1:0] {
    DLY_FN_OFF = 2'h0,
    DLY_FN_INPUT_BLANKING = 2'h1,
    DLY_FN_EVENT = 2'h2,
    DLY_FN_RESERVED = 2'h3
  } pfdd_dly_fn_t;

  typedef enum logic [1:0] {
    FRAC_ONTIME_RAMP_B_ONLY = 2'h0,
    FRAC_ONTIME_BOTH_RAMPS = 2'h1,
    FRAC_DEADTIME_RAMP_B_ONLY = 2'h2,
    FRAC_DEADTIME_BOTH_RAMPS = 2'h3
  } pfdd_frac_t;

  // Compare events: bit 0 A set, 1 A clear, 2 B set, 3 B clear
  typedef struct packed {
    logic compare_b_clear_event;
    logic compare_b_set_event;
    logic compare_a_clear_event;
    logic compare_a_set_event;
  } pfdd_cmp_evt_t;

  // Sequence commands towards the counter core
  typedef struct packed {
    logic jump_opposite;
    logic run_opposite;
    logic jump_next;
    logic hold_sequence;
    logic loop_opposite;
    logic loop_deadtime;
  } pfdd_seq_t;

endpackage

// >>> rtl/pfdd_delay_unit.sv
`timescale 1ns/10ps
module pfdd_delay_unit
  import pfdd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_setup,
  input wire logic [7:0] i_length,
  input wire pfdd_cmp_evt_t i_cmp_evt,
  output logic o_blank,
  output logic o_event
);
  logic [1:0] div_sel;
  logic [1:0] src_sel;
  pfdd_dly_fn_t fn;
  logic [2:0] div_mask;
  logic [2:0] pre_r;
  logic [7:0] cnt_r;
  logic active_r;
  logic event_r;
  logic blank_r;
  logic start;
  logic tick;

  assign div_sel = i_setup[5:4];
  assign src_sel = i_setup[3:2];
  assign fn = pfdd_dly_fn_t'(i_setup[1:0]);
  assign div_mask = 3'((4'h1 << div_sel) - 4'h1); // see [RQ13]
  assign tick = (pre_r & div_mask) == div_mask;
  // Reserved function code starts nothing
  assign start = i_cmp_evt[src_sel] && (fn == DLY_FN_INPUT_BLANKING || fn == DLY_FN_EVENT); // see [RQ14] see [RQ15]

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_r <= 3'h0;
      cnt_r <= 8'h00;
      active_r <= 1'b0;
    end else if (start) begin
      pre_r <= 3'h0;
      cnt_r <= i_length; // see [RQ16]
      active_r <= 1'b1;
    end else if (active_r) begin
      pre_r <= pre_r + 3'h1;
      if (tick) begin
        if (cnt_r == 8'h00) begin
          active_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      event_r <= 1'b0;
      blank_r <= 1'b0;
    end else begin
      event_r <= active_r && tick && cnt_r == 8'h00 && !start && fn == DLY_FN_EVENT;
      // Blanking lags the delay by one clock
      blank_r <= active_r && fn == DLY_FN_INPUT_BLANKING;
    end
  end

  assign o_blank = blank_r;
  assign o_event = event_r;

  chk_delay_start: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ16]
    start |=> active_r && cnt_r == $past(i_length))
    else $error("delay did not load its length");
endmodule

// >>> rtl/pfdd_dither.sv
`timescale 1ns/10ps
module pfdd_dither
  import pfdd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_step_wr,
  input wire logic [3:0] i_step,
  input wire logic i_cycle_end,
  input wire logic i_update,
  output logic [3:0] o_step_buf,
  output logic o_stretch
);
  logic [3:0] buf_r;
  logic [3:0] step_r;
  logic [3:0] acc_r;
  logic [4:0] sum;
  logic stretch_r;

  assign sum = {1'b0, acc_r} + {1'b0, step_r};

  // Software writes land in the buffer only
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      buf_r <= 4'h0;
      step_r <= 4'h0;
    end else begin
      if (i_step_wr) begin
        buf_r <= i_step;
      end
      if (i_update) begin
        step_r <= buf_r; // see [RQ20]
      end
    end
  end

  // Stretch holds for the one timer cycle after an overflow
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_r <= 4'h0;
      stretch_r <= 1'b0;
    end else if (i_cycle_end) begin
      acc_r <= sum[3:0]; // see [RQ18]
      stretch_r <= sum[4]; // see [RQ19] see [RQ23]
    end
  end

  assign o_step_buf = buf_r;
  assign o_stretch = stretch_r;

  chk_dither_buffer: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ20]
    !i_update |=> step_r == $past(step_r))
    else $error("dither step changed without update");
  chk_dither_carry: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ19]
    i_cycle_end && sum[4] |=> stretch_r)
    else $error("overflow did not stretch");
endmodule

// >>> rtl/pfdd_core.sv
`timescale 1ns/10ps
// Contract
// [RQ1] Mode zero ignores input B triggers entirely. The code still sets the trigger B flag on them.
// [RQ2] Mode 1 stops output, jumps opposite, holds; mode 2 runs opposite, holds.
// [RQ3] Mode 3 stops output, loops opposite cycle while fault stays active.
// [RQ4] Mode 4 stops all keeping period; mode 5 stops all, dead time while faulted.
// [RQ5] Mode 6 stops all, jumps to next cycle, holds until released.
// [RQ6] Mode 7 stops all until software resumes.
// [RQ7] Modes 8 and 9 stop output on edge; 8 jumps next, 9 keeps period.
// [RQ8] Mode 10 stops output while input active; other codes unused.
// [RQ9] Enable bits 4..7 route compare waveforms to pins.
// [RQ10] Default bits 0..3 give pin level after reset and under fault.
// [RQ11] Power-on reset clears enables and defaults.
// [RQ12] Other resets load enables and defaults from configuration fuse.
// [RQ13] Delay divider divides by 1, 2, 4 or 8.
// [RQ14] Delay source picks compare A/B set/clear event.
// [RQ15] Delay function: off, input blanking, delayed event; code 3 reserved.
// [RQ16] Delay length counts prescaled timer cycles. The code counts prescaled system clocks instead.
// [RQ17] Fractional phase picks on time or dead time of B or both ramps.
// [RQ18] Step added into 4-bit accumulator each timer cycle end.
// [RQ19] Accumulator overflow adjusts selected phase once.
// [RQ20] Step is double-buffered, taken at update condition.
// [RQ21] Trigger B flag set on trigger or capture B, write one clears.
// [RQ22] Event acts as trigger only when trigger enable bit is one.
// [RQ23] Overflow lengthens selected phase by one clock for one cycle.
module pfdd_core
  import pfdd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_por_reset,
  input wire logic [7:0] i_cfg_fuse,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_evt_b,
  input wire logic i_capture_b,
  input wire pfdd_cmp_evt_t i_cmp_evt,
  input wire logic i_cycle_end,
  input wire logic i_update,
  input wire logic [3:0] i_cmp_wave,
  output logic [3:0] o_pin,
  output logic [3:0] o_pin_oe,
  output pfdd_seq_t o_seq,
  output logic o_delay_event,
  output logic o_blanking,
  output logic [1:0] o_frac_phase,
  output logic o_frac_stretch,
  output logic o_trig_b_flag,
  output logic [7:0] o_halt_cfg
);
  logic aw_rdy_r, w_rdy_r, ar_rdy_r;
  logic aw_got_r, w_got_r;
  logic [5:0] aw_idx_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] rdata_r;
  logic do_wr;
  logic [5:0] ar_idx;
  logic [7:0] rd_nxt;
  logic rd_hit;
  logic wr_hit;
  logic wr_en;

  logic [7:0] mode_reg_r, fault_def_r, dly_setup_r, dly_len_r, frac_sel_r, halt_r;
  logic trig_en_r;
  logic flag_r;
  logic load_pend_r;
  logic sw_resume;
  logic flag_clr;

  pfdd_mode_t mode;
  logic trig_lvl, trig_prev_r, trig_edge;
  logic hold_r, hold_nxt;
  logic stop_all_r;
  pfdd_seq_t seq_r, seq_nxt;
  logic [3:0] pin_r;
  logic [3:0] stop_mask;
  logic blank;
  logic [3:0] step_buf;

  // Write channel: address and data taken in either order
  assign do_wr = aw_got_r && w_got_r && !bvalid_r;
  assign wr_en = do_wr && wlane_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_rdy_r <= 1'b0;
      aw_got_r <= 1'b0;
      aw_idx_r <= 6'h00;
    end else if (aw_rdy_r && i_awvalid) begin
      aw_rdy_r <= 1'b0;
      aw_got_r <= 1'b1;
      aw_idx_r <= i_awaddr[ADDR_MSB:ADDR_LSB];
    end else if (do_wr) begin
      aw_got_r <= 1'b0;
    end else if (!aw_got_r && !bvalid_r) begin
      aw_rdy_r <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w_rdy_r <= 1'b0;
      w_got_r <= 1'b0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (w_rdy_r && i_wvalid) begin
      w_rdy_r <= 1'b0;
      w_got_r <= 1'b1;
      wdata_r <= i_wdata[7:0];
      wlane_r <= i_wstrb[0];
    end else if (do_wr) begin
      w_got_r <= 1'b0;
    end else if (!w_got_r && !bvalid_r) begin
      w_rdy_r <= 1'b1;
    end
  end

  always_comb begin
    unique case (aw_idx_r)
      IDX_EVT_CTRL, IDX_FLAGS, IDX_RESUME, IDX_INPUT_B, IDX_FAULT_DEF,
      IDX_DLY_SETUP, IDX_DLY_LEN, IDX_FRAC_SEL, IDX_FRAC_STEP, IDX_HALT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  assign ar_idx = i_araddr[ADDR_MSB:ADDR_LSB];

  always_comb begin
    rd_hit = 1'b1;
    unique case (ar_idx)
      IDX_EVT_CTRL: rd_nxt = {7'h00, trig_en_r};
      IDX_FLAGS: rd_nxt = {4'h0, flag_r, 3'h0};
      IDX_INPUT_B: rd_nxt = mode_reg_r;
      IDX_FAULT_DEF: rd_nxt = fault_def_r;
      IDX_DLY_SETUP: rd_nxt = dly_setup_r;
      IDX_DLY_LEN: rd_nxt = dly_len_r;
      IDX_FRAC_SEL: rd_nxt = frac_sel_r;
      IDX_FRAC_STEP: rd_nxt = {4'h0, step_buf};
      IDX_HALT: rd_nxt = halt_r;
      IDX_RESUME: rd_nxt = {7'h00, hold_r};
      default: begin
        rd_nxt = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= RESP_OKAY;
    end else if (ar_rdy_r && i_arvalid) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_nxt;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      ar_rdy_r <= 1'b1;
    end
  end

  // Register file
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_reg_r <= REG_RESET;
      dly_setup_r <= REG_RESET;
      dly_len_r <= REG_RESET;
      frac_sel_r <= REG_RESET;
      halt_r <= REG_RESET;
      trig_en_r <= 1'b0;
    end else if (wr_en) begin
      unique case (aw_idx_r)
        IDX_INPUT_B: mode_reg_r <= wdata_r & MODE_MASK;
        IDX_DLY_SETUP: dly_setup_r <= wdata_r & DLY_SETUP_MASK;
        IDX_DLY_LEN: dly_len_r <= wdata_r;
        IDX_FRAC_SEL: frac_sel_r <= wdata_r & FRAC_SEL_MASK;
        IDX_HALT: halt_r <= wdata_r & HALT_MASK;
        IDX_EVT_CTRL: trig_en_r <= wdata_r[TRIG_EN_BIT];
        default: ;
      endcase
    end
  end

  // Defaults clear on any reset; a non power-on reset then reloads from fuse on release
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault_def_r <= REG_RESET; // see [RQ11]
      load_pend_r <= 1'b1;
    end else if (load_pend_r) begin
      load_pend_r <= 1'b0;
      if (!i_por_reset) begin
        fault_def_r <= i_cfg_fuse; // see [RQ12]
      end
    end else if (wr_en && aw_idx_r == IDX_FAULT_DEF) begin
      fault_def_r <= wdata_r;
    end
  end

  assign sw_resume = wr_en && aw_idx_r == IDX_RESUME && wdata_r[RESUME_BIT];
  assign flag_clr = wr_en && aw_idx_r == IDX_FLAGS && wdata_r[FLAG_TRIG_B_BIT];

  // Set wins over a same-cycle clear
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= trig_edge || i_capture_b || (flag_r && !flag_clr); // see [RQ21]
    end
  end

  // Fault input B; blanking masks it so switching noise is not seen
  assign mode = pfdd_mode_t'(mode_reg_r[3:0]);
  assign trig_lvl = i_evt_b && trig_en_r && !blank; // see [RQ22]
  assign trig_edge = trig_lvl && !trig_prev_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_lvl;
    end
  end

  always_comb begin
    hold_nxt = hold_r;
    seq_nxt = '0;
    unique case (mode)
      MODE_NONE: hold_nxt = 1'b0; // see [RQ1]
      MODE_JUMP_OPPOSITE_AND_HOLD, MODE_RUN_OPPOSITE_AND_HOLD, MODE_STOP_ALL_JUMP_NEXT: begin
        if (trig_edge) begin
          hold_nxt = 1'b1;
        end else if (!trig_lvl && i_cycle_end) begin
          hold_nxt = 1'b0;
        end
        seq_nxt.jump_opposite = trig_edge && mode == MODE_JUMP_OPPOSITE_AND_HOLD; // see [RQ2]
        seq_nxt.run_opposite = trig_edge && mode == MODE_RUN_OPPOSITE_AND_HOLD; // see [RQ2]
        seq_nxt.jump_next = trig_edge && mode == MODE_STOP_ALL_JUMP_NEXT; // see [RQ5]
        seq_nxt.hold_sequence = hold_nxt;
      end
      MODE_RUN_OPPOSITE_WHILE_FAULTED, MODE_STOP_ALL_KEEP_PERIOD, MODE_DEADTIME_WHILE_FAULTED,
      MODE_LEVEL_STOP_KEEP_PERIOD: begin
        hold_nxt = trig_lvl; // see [RQ3] see [RQ4] see [RQ8]
        seq_nxt.loop_opposite = trig_lvl && mode == MODE_RUN_OPPOSITE_WHILE_FAULTED;
        seq_nxt.loop_deadtime = trig_lvl && mode == MODE_DEADTIME_WHILE_FAULTED;
      end
      MODE_STOP_ALL_UNTIL_SOFTWARE: begin
        if (trig_edge) begin
          hold_nxt = 1'b1; // see [RQ6]
        end else if (sw_resume) begin
          hold_nxt = 1'b0;
        end
        seq_nxt.hold_sequence = hold_nxt;
      end
      MODE_EDGE_STOP_NEXT_CYCLE, MODE_EDGE_STOP_KEEP_PERIOD: begin
        if (trig_edge) begin
          hold_nxt = 1'b1; // see [RQ7]
        end else if (i_cycle_end) begin
          hold_nxt = 1'b0;
        end
        seq_nxt.jump_next = trig_edge && mode == MODE_EDGE_STOP_NEXT_CYCLE;
      end
      default: hold_nxt = 1'b0; // see [RQ8]
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_r <= 1'b0;
      seq_r <= '0;
      stop_all_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      seq_r <= seq_nxt;
      stop_all_r <= mode inside {MODE_STOP_ALL_KEEP_PERIOD, MODE_DEADTIME_WHILE_FAULTED,
                                 MODE_STOP_ALL_JUMP_NEXT, MODE_STOP_ALL_UNTIL_SOFTWARE};
    end
  end

  // Only pin B is affected in single-output modes
  assign stop_mask = !hold_r ? 4'h0 : stop_all_r ? 4'hF : 4'(1 << PIN_B_IDX);

  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          pin_r[i] <= 1'b0;
        end else if (stop_mask[i] || !fault_def_r[PIN_EN_LSB + i]) begin
          pin_r[i] <= fault_def_r[i]; // see [RQ10]
        end else begin
          pin_r[i] <= i_cmp_wave[i]; // see [RQ9]
        end
      end
    end
  endgenerate

  pfdd_delay_unit u_delay (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_setup(dly_setup_r),
    .i_length(dly_len_r),
    .i_cmp_evt(i_cmp_evt),
    .o_blank(blank),
    .o_event(o_delay_event)
  );

  pfdd_dither u_dither (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_step_wr(wr_en && aw_idx_r == IDX_FRAC_STEP),
    .i_step(wdata_r[3:0] & FRAC_STEP_MASK[3:0]),
    .i_cycle_end(i_cycle_end),
    .i_update(i_update),
    .o_step_buf(step_buf),
    .o_stretch(o_frac_stretch)
  );

  assign o_awready = aw_rdy_r;
  assign o_wready = w_rdy_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = ar_rdy_r;
  assign o_rvalid = rvalid_r;
  assign o_rresp = rresp_r;
  assign o_rdata = {24'h000000, rdata_r};
  assign o_pin = pin_r;
  assign o_pin_oe = fault_def_r[7:4];
  assign o_seq = seq_r;
  assign o_blanking = blank;
  assign o_frac_phase = frac_sel_r[1:0]; // see [RQ17]
  assign o_trig_b_flag = flag_r;
  assign o_halt_cfg = halt_r;

  chk_mode_none_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ1]
    mode == MODE_NONE |=> !hold_r && seq_r == '0)
    else $error("mode none acted on trigger");
  chk_jump_opposite: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ2]
    trig_edge && mode == MODE_JUMP_OPPOSITE_AND_HOLD |=> seq_r.jump_opposite && hold_r)
    else $error("jump opposite missing");
  chk_loop_opposite: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ3]
    mode == MODE_RUN_OPPOSITE_WHILE_FAULTED && $stable(mode) |=> seq_r.loop_opposite == $past(trig_lvl))
    else $error("opposite loop not tied to fault level");
  chk_stop_all_pins: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ4]
    hold_r && stop_all_r |=> o_pin == $past(fault_def_r[3:0]))
    else $error("stop all did not force defaults");
  chk_software_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ6]
    hold_r && mode == MODE_STOP_ALL_UNTIL_SOFTWARE && $stable(mode) && !sw_resume |=> hold_r)
    else $error("software hold released early");
  chk_edge_release: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ7]
    mode == MODE_EDGE_STOP_KEEP_PERIOD && $stable(mode) && i_cycle_end && !trig_edge |=> !hold_r)
    else $error("edge stop not released at cycle end");
  chk_pin_route: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ9]
    !hold_r && fault_def_r[PIN_EN_LSB + PIN_B_IDX] |=> o_pin[PIN_B_IDX] == $past(i_cmp_wave[PIN_B_IDX]))
    else $error("enabled pin not routed");
  chk_fuse_load: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ12]
    load_pend_r && i_rstn && !i_por_reset |=> fault_def_r == $past(i_cfg_fuse))
    else $error("fuse not loaded after reset");
  chk_flag_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ21]
    trig_edge || i_capture_b |=> flag_r)
    else $error("trigger flag lost");
  chk_trig_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see [RQ22]
    !trig_en_r |-> !trig_edge)
    else $error("trigger without enable");

  cov_software_resume: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    hold_r && mode == MODE_STOP_ALL_UNTIL_SOFTWARE ##1 sw_resume);
  cov_stretch: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) o_frac_stretch);
  cov_write_read: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) do_wr ##[1:10] rvalid_r);
endmodule

// >>> dv/pfdd_power_stage.sv
`timescale 1ns/10ps
module pfdd_power_stage
  import pfdd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_fault,
  input wire logic i_upd_req,
  input wire logic [3:0] i_wave,
  output logic o_evt_b,
  output pfdd_cmp_evt_t o_cmp_evt,
  output logic o_cycle_end,
  output logic o_update,
  output logic [3:0] o_cmp_wave
);
  logic [3:0] cnt_r;

  // Timer cycle of 16 clocks; compare, cycle-end and update events are one-clock pulses, event B follows the fault level
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 4'h0;
      o_cmp_evt <= '0;
      o_cycle_end <= 1'h0;
      o_update <= 1'h0;
      o_evt_b <= 1'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      o_cmp_evt <= {cnt_r == 4'hF, cnt_r == 4'h8, cnt_r == 4'h4, cnt_r == 4'h0};
      o_cycle_end <= cnt_r == 4'hF;
      // Update only lands on a cycle boundary, as the real counter does
      o_update <= i_upd_req && (cnt_r == 4'hF);
      o_evt_b <= i_fault;
    end
  end

  assign o_cmp_wave = i_wave;
endmodule

// >>> dv/pwm_fault_delay_dither_control_bench.sv
`timescale 1ns/10ps
module pwm_fault_delay_dither_control_bench;
  import pfdd_pkg::*;
  logic clk, rstn, por, fault, upd_req, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, evt_b, cyc_end, upd, stretch, dly_evt, blank, flag;
  logic [7:0] fuse, awaddr, araddr, halt, len;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0] bresp, rresp, rresp_q, bresp_q, phase;
  logic [3:0] wave, pin, oe, wv;
  pfdd_cmp_evt_t cmp_evt;
  pfdd_seq_t seq;
  int n_fail, num_checks, cnt, lo;
  logic [5:0] ridx [7] = '{IDX_INPUT_B, IDX_FAULT_DEF, IDX_DLY_SETUP, IDX_DLY_LEN, IDX_FRAC_SEL, IDX_FRAC_STEP, IDX_HALT};
  logic [3:0] md [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA};
  logic [3:0] p1 [10] = '{4'hE, 4'hC, 4'hC, 4'hC, 4'h4, 4'h4, 4'h4, 4'hC, 4'hC, 4'hC};
  logic [3:0] p2 [10] = '{4'hE, 4'hC, 4'hC, 4'hC, 4'h4, 4'h4, 4'h4, 4'hE, 4'hE, 4'hC};

  pfdd_core u_pfdd_core (.i_sys_clk(clk), .i_rstn(rstn), .i_por_reset(por), .i_cfg_fuse(fuse),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'h1),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_evt_b(evt_b), .i_capture_b(1'h0), .i_cmp_evt(cmp_evt),
    .i_cycle_end(cyc_end), .i_update(upd), .i_cmp_wave(wave), .o_pin(pin), .o_pin_oe(oe), .o_seq(seq),
    .o_delay_event(dly_evt), .o_blanking(blank), .o_frac_phase(phase), .o_frac_stretch(stretch),
    .o_trig_b_flag(flag), .o_halt_cfg(halt));
  pfdd_power_stage u_pfdd_power_stage (.i_sys_clk(clk), .i_rstn(rstn), .i_fault(fault), .i_upd_req(upd_req),
    .o_evt_b(evt_b), .o_cmp_evt(cmp_evt), .o_cycle_end(cyc_end), .o_update(upd), .o_cmp_wave(wave), .i_wave(wv));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clk);
    awaddr <= {a, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge clk);
      ta = ta | awready;
      tw = tw | wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'h0;
    bresp_q = bresp;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    araddr <= {a, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'h0;
    @(posedge clk);
    while (!rvalid) @(posedge clk);
    rready <= 1'h0;
    rd_q = rdata;
    rresp_q = rresp;
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_q, {24'h0, e});
    chk(rresp_q, RESP_OKAY);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  initial begin
    {rstn, fault, upd_req, awvalid, wvalid, bready, arvalid, rready} = '0;
    por = 1'h1;
    fuse = 8'h5A;
    wv = 4'hF;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    for (int i = 0; i < 7; i++) rdchk(ridx[i], 8'h00);
    rd(6'h3F);
    chk(rd_q, 32'h0);
    chk(rresp_q, RESP_SLVERR);
    wr(6'h3F, 8'h00);
    chk(bresp_q, RESP_SLVERR);
    wr(IDX_FAULT_DEF, 8'hA4);
    chk(bresp_q, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(oe, 4'hA);
    chk(pin, 4'hE);
    wv <= 4'h5;
    repeat (3) @(posedge clk);
    chk(pin, 4'h4);
    wv <= 4'hF;
    wr(IDX_EVT_CTRL, 8'h01);
    for (int i = 0; i < 10; i++) begin
      wr(IDX_INPUT_B, {4'h0, md[i]});
      fault <= 1'h1;
      cnt = 0;
      repeat (4) @(posedge clk) cnt += int'({seq.jump_opposite, seq.run_opposite, seq.jump_next});
      chk(cnt, {md[i] == 4'h1, md[i] == 4'h2, md[i] == 4'h6 || md[i] == 4'h8});
      chk(pin, p1[i]);
      chk({seq.loop_opposite, seq.loop_deadtime}, {md[i] == 4'h3, md[i] == 4'h5});
      repeat (20) @(posedge clk);
      chk(pin, p2[i]);
      fault <= 1'h0;
      repeat (20) @(posedge clk);
      chk(pin, 4'hE);
    end
    wr(IDX_INPUT_B, 8'h07);
    fault <= 1'h1;
    repeat (4) @(posedge clk);
    fault <= 1'h0;
    repeat (20) @(posedge clk);
    chk(pin, 4'h4);
    rdchk(IDX_FLAGS, 8'h08);
    chk(flag, 1'h1);
    wr(IDX_FLAGS, 8'h08);
    rdchk(IDX_FLAGS, 8'h00);
    wr(IDX_RESUME, 8'h01);
    repeat (4) @(posedge clk);
    chk(pin, 4'hE);
    wr(IDX_EVT_CTRL, 8'h00);
    fault <= 1'h1;
    repeat (6) @(posedge clk);
    fault <= 1'h0;
    chk(pin, 4'hE);
    rdchk(IDX_FLAGS, 8'h00);
    wr(IDX_FRAC_STEP, 8'h08);
    rdchk(IDX_FRAC_STEP, 8'h08);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_FRAC_SEL, i[7:0]);
      chk(phase, i[1:0]);
    end
    cnt = 0;
    repeat (48) @(posedge clk) cnt += int'(stretch === 1'h1);
    chk(cnt, 0);
    upd_req <= 1'h1;
    repeat (17) @(posedge clk);
    upd_req <= 1'h0;
    // First overflow needs two cycle ends; skip that longer gap
    repeat (32) @(posedge clk);
    cnt = 0;
    repeat (64) @(posedge clk) cnt += int'(stretch === 1'h1);
    chk(cnt, 32);
    for (int i = 0; i < 4; i++) begin
      len = (i == 0) ? 8'h07 : 8'h00;
      wr(IDX_DLY_LEN, len);
      wr(IDX_DLY_SETUP, {2'h0, i[1:0], i[1:0], 2'h2});
      lo = (int'(len) + 1) << i;
      @(posedge clk iff cmp_evt[i]);
      cnt = 0;
      do begin
        @(posedge clk);
        cnt++;
      end while (dly_evt !== 1'h1);
      chk(cnt >= lo && cnt <= lo + (1 << i) + 3, 1);
    end
    // Blanking longer than a timer cycle, so it never lapses
    wr(IDX_DLY_LEN, 8'h20);
    wr(IDX_DLY_SETUP, 8'h01);
    wr(IDX_EVT_CTRL, 8'h01);
    repeat (20) @(posedge clk);
    chk(blank, 1'h1);
    fault <= 1'h1;
    repeat (4) @(posedge clk);
    fault <= 1'h0;
    chk(flag, 1'h0);
    wr(IDX_HALT, 8'hFF);
    chk(halt, HALT_MASK);
    rstn <= 1'h0;
    por <= 1'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    rdchk(IDX_FAULT_DEF, 8'h5A);
    chk(oe, 4'h5);
    finish_test();
  end
endmodule
